// ### logic/flash_fe_pkg.sv
// Shared constants and types of the serial flash front end.
// Assumes a single core clock; all pin timing is sampled by that clock.
package flash_fe_pkg;
   localparam int SYNC_STAGES = 3;
   localparam int NUM_PAGES = 512;
   localparam int PAGE_BIG = 264;
   localparam int PAGE_SMALL = 256;
   localparam int BLOCK_PAGES = 8;
   localparam int SECTOR_PAGES = 128;
   localparam int SEC_BYTES = 128;
   localparam int SEC_USER_BYTES = 64;
   localparam int MEM_BYTES = NUM_PAGES * PAGE_BIG;
   localparam int FIFO_DEPTH = 8;
   localparam int ADDR_BYTES = 3;
   localparam logic [2:0] BYTES_CMD_ADDR = 3'd4;
   localparam logic [2:0] BYTES_CMD_ONLY = 3'd1;
   localparam logic RST_PAGE256 = 1'b0;
   localparam logic [8:0] BIG_LAST = 9'h107;
   localparam logic [8:0] SMALL_LAST = 9'h0ff;
   localparam logic [8:0] SEC_LAST = 9'h07f;
   localparam logic [8:0] SEC_USER_LAST = 9'h03f;
   localparam logic [7:0] OP_STATUS = 8'h05;
   localparam logic [7:0] OP_ID = 8'h9f;
   localparam logic [7:0] OP_BUF_WRITE = 8'h10;
   localparam logic [7:0] OP_BUF_READ = 8'h11;
   localparam logic [7:0] OP_MEM_READ = 8'h12;
   localparam logic [7:0] OP_PROGRAM = 8'h13;
   localparam logic [7:0] OP_ERASE_PAGE = 8'h20;
   localparam logic [7:0] OP_ERASE_BLOCK = 8'h21;
   localparam logic [7:0] OP_ERASE_SECTOR = 8'h22;
   localparam logic [7:0] OP_ERASE_CHIP = 8'h23;
   localparam logic [7:0] OP_SEC_READ = 8'h30;
   localparam logic [7:0] OP_SEC_PROG = 8'h31;
   localparam logic [7:0] OP_PAGE256 = 8'h40;
   localparam logic [7:0] OP_PAGE264 = 8'h41;

   typedef enum logic [1:0] {
      ENG_IDLE = 2'b00,
      ENG_PROG = 2'b01,
      ENG_ERASE = 2'b10,
      ENG_SECPROG = 2'b11
   } eng_state_t;

   typedef struct packed {
      logic [8:0] page;
      logic [8:0] col;
   } ptr_t;

   typedef struct packed {
      logic [8:0] col;
      logic [7:0] data;
   } buf_word_t;
endpackage

// ### logic/serial_flash_fe.sv
// Serial flash front end: pin sampler, command decoder, page buffer,
// array and self-timed program/erase engine, plus its write FIFO.
// Assumes pins are asynchronous to CLOCK_IN and the link clock is slow
// enough (a few core cycles per phase) for edge detection.
//
// Contract
// R01: Select low selects, high gives standby
// R02: Output undriven while deselected
// R03: Input ignored while deselected
// R04: Operations start and end on select edges
// R05: Standby waits for self-timed operation end
// R06: Input bits taken on clock rise
// R07: Output bits change on clock fall
// R08: Clock may idle low or high
// R09: Host keeps clock under its maximum
// R10: 512 pages of 256 or 264 bytes
// R11: One buffer sized to the page
// R12: Program and erase run self-timed
// R13: Erase page, block, sector or chip
// R14: 128 bytes: 64 user, 64 unique
// R15: Identification read returns maker and device
// R16: Opcode first, then address, then decode
// R17: Everything shifts most significant bit first
// R18: Host waits for busy end before more
`timescale 1ns/1ps

module fe_fifo #(
   parameter int WIDTH = 17,
   parameter int DEPTH = 8
) (
   input wire logic clk_in, // Core clock
   input wire logic nrst_in, // Async reset, low
   input wire logic [WIDTH-1:0] wr_data_in, // Word to store
   input wire logic wr_valid_in, // Word offered
   output logic wr_ready_out, // Room left
   output logic [WIDTH-1:0] rd_data_out, // Oldest word
   output logic rd_valid_out, // Word waiting
   input wire logic rd_ready_in // Drain takes word
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   logic [WIDTH-1:0] mem [0:DEPTH-1];
   logic [AW-1:0] wr_ptr_ff;
   logic [AW-1:0] rd_ptr_ff;
   logic [AW:0] count_ff;
   logic push;
   logic pop;

   assign wr_ready_out = (count_ff != (AW+1)'(DEPTH));
   assign rd_valid_out = (count_ff != '0);
   assign rd_data_out = mem[rd_ptr_ff];
   assign push = wr_valid_in && wr_ready_out;
   assign pop = rd_valid_out && rd_ready_in;

   always_ff @(posedge clk_in) begin
      if (push) begin
         mem[wr_ptr_ff] <= wr_data_in;
      end
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         count_ff <= '0;
      end else begin
         if (push) begin
            wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
         end
         if (pop) begin
            rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
         end
         count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

module serial_flash_fe #(
   parameter logic [7:0] MAKER_ID = 8'h5a, // Arbitrary value
   parameter logic [7:0] DEVICE_ID = 8'ha5, // Arbitrary value
   parameter logic [7:0] UID_SEED = 8'h3c // Arbitrary value
) (
   input wire logic CLOCK_IN, // Core clock, 40 MHz
   input wire logic NRST_IN, // Async reset, low
   input wire logic SEL_N_IN, // Device select pin, low
   input wire logic SCLK_IN, // Serial clock pin
   input wire logic SDI_IN, // Serial data in pin
   output logic SDO_OUT, // Serial data out
   output logic SDO_OE_OUT, // Data out enable, high
   output logic STANDBY_OUT // In standby
);
   logic [flash_fe_pkg::SYNC_STAGES-1:0] sel_sync_ff;
   logic [flash_fe_pkg::SYNC_STAGES-1:0] sck_sync_ff;
   logic [flash_fe_pkg::SYNC_STAGES-1:0] sdi_sync_ff;
   logic desel_lvl_ff;
   logic sck_lvl_ff;
   logic sdi_lvl_ff;
   logic sck_rise;
   logic sck_fall;
   logic sel_fall;
   logic sel_rise;
   logic [2:0] bit_cnt_ff;
   logic [2:0] bytes_ff;
   logic [7:0] rx_ff;
   logic [7:0] cmd_ff;
   logic [23:0] addr_ff;
   logic [7:0] rx_new;
   logic last_bit;
   logic [7:0] tx_byte_ff;
   logic tx_en_ff;
   logic sdo_ff;
   logic sdo_oe_ff;
   logic standby_ff;
   logic page256_ff;
   logic overrun_ff;
   flash_fe_pkg::ptr_t rd_ptr_ff;
   logic [8:0] wr_col_ff;
   logic [7:0] main_mem [0:flash_fe_pkg::MEM_BYTES-1];
   logic [7:0] page_buf [0:flash_fe_pkg::PAGE_BIG-1];
   logic [7:0] sec_user [0:flash_fe_pkg::SEC_USER_BYTES-1];
   flash_fe_pkg::eng_state_t eng_state_ff;
   logic [8:0] eng_page_ff;
   logic [8:0] eng_last_ff;
   logic [8:0] eng_col_ff;
   logic [8:0] col_last;
   logic busy;
   logic [17:0] eng_index;
   flash_fe_pkg::buf_word_t push_word;
   flash_fe_pkg::buf_word_t pop_word;
   logic push_valid;
   logic push_ready;
   logic pop_valid;
   logic pop_ready;
   logic load_now;
   logic [7:0] fetch_cmd;
   flash_fe_pkg::ptr_t fetch_ptr;
   flash_fe_pkg::ptr_t nxt_rd_ptr;
   logic [7:0] fetch_byte;
   flash_fe_pkg::ptr_t launch_ptr;

   function automatic flash_fe_pkg::ptr_t decode(input logic [23:0] a, input logic p256);
      flash_fe_pkg::ptr_t p;
      if (p256) begin
         p.page = a[16:8];
         p.col = {1'b0, a[7:0]};
      end else begin
         p.page = a[17:9];
         p.col = (a[8:0] > flash_fe_pkg::BIG_LAST) ? 9'h000 : a[8:0];
      end
      return p;
   endfunction

   function automatic logic [17:0] flat(input logic [8:0] page, input logic [8:0] col);
      return 18'(page) * 18'(flash_fe_pkg::PAGE_BIG) + 18'(col);
   endfunction

   // Pin samplers; a level moves once the last two stages agree
   always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         sel_sync_ff <= '1;
         sck_sync_ff <= '0;
         sdi_sync_ff <= '0;
      end else begin
         sel_sync_ff <= {sel_sync_ff[1:0], SEL_N_IN};
         sck_sync_ff <= {sck_sync_ff[1:0], SCLK_IN};
         sdi_sync_ff <= {sdi_sync_ff[1:0], SDI_IN};
      end
   end

   always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         desel_lvl_ff <= 1'b1;
         sck_lvl_ff <= 1'b0;
         sdi_lvl_ff <= 1'b0;
      end else begin
         if (sel_sync_ff[1] == sel_sync_ff[2]) begin
            desel_lvl_ff <= sel_sync_ff[2];
         end
         if (sck_sync_ff[1] == sck_sync_ff[2]) begin
            sck_lvl_ff <= sck_sync_ff[2];
         end
         if (sdi_sync_ff[1] == sdi_sync_ff[2]) begin
            sdi_lvl_ff <= sdi_sync_ff[2];
         end
      end
   end

   assign sck_rise = (sck_sync_ff[1] == sck_sync_ff[2]) && sck_sync_ff[2] && !sck_lvl_ff;
   assign sck_fall = (sck_sync_ff[1] == sck_sync_ff[2]) && !sck_sync_ff[2] && sck_lvl_ff;
   assign sel_fall = (sel_sync_ff[1] == sel_sync_ff[2]) && !sel_sync_ff[2] && desel_lvl_ff;
   assign sel_rise = (sel_sync_ff[1] == sel_sync_ff[2]) && sel_sync_ff[2] && !desel_lvl_ff;

   assign rx_new = {rx_ff[6:0], sdi_lvl_ff}; // R17
   assign last_bit = sck_rise && !desel_lvl_ff && (bit_cnt_ff == 3'd7);
   assign busy = (eng_state_ff != flash_fe_pkg::ENG_IDLE);
   assign col_last = page256_ff ? flash_fe_pkg::SMALL_LAST : flash_fe_pkg::BIG_LAST; // R11

   // Receive shifter and opcode/address capture
   always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         bit_cnt_ff <= '0;
         bytes_ff <= '0;
         rx_ff <= '0;
         cmd_ff <= '0;
         addr_ff <= '0;
      end else if (desel_lvl_ff || sel_fall) begin
         bit_cnt_ff <= '0; // R03 R04
         bytes_ff <= '0;
         rx_ff <= '0;
      end else if (sck_rise) begin
         rx_ff <= rx_new; // R06
         bit_cnt_ff <= bit_cnt_ff + 3'd1;
         if (last_bit) begin
            if (bytes_ff != flash_fe_pkg::BYTES_CMD_ADDR) begin
               bytes_ff <= bytes_ff + 3'd1;
            end
            if (bytes_ff == 3'd0) begin
               cmd_ff <= rx_new; // R16
            end else if (bytes_ff <= 3'(flash_fe_pkg::ADDR_BYTES)) begin
               addr_ff <= {addr_ff[15:0], rx_new};
            end
         end
      end
   end

   // Read data source selection
   always_comb begin
      fetch_cmd = (bytes_ff == 3'd0) ? rx_new : cmd_ff;
      fetch_ptr = rd_ptr_ff;
      if (bytes_ff == 3'd0) begin
         fetch_ptr = '0;
      end else if ((bytes_ff == 3'(flash_fe_pkg::ADDR_BYTES)) && !tx_en_ff) begin
         fetch_ptr = decode({addr_ff[15:0], rx_new}, page256_ff);
         if (cmd_ff == flash_fe_pkg::OP_SEC_READ) begin
            fetch_ptr.col = {2'b00, rx_new[6:0]};
         end
      end
      load_now = 1'b0;
      if (last_bit) begin
         if (bytes_ff == 3'd0) begin
            load_now = (rx_new == flash_fe_pkg::OP_STATUS) || (rx_new == flash_fe_pkg::OP_ID);
         end else if (bytes_ff == 3'(flash_fe_pkg::ADDR_BYTES)) begin
            load_now = tx_en_ff || (cmd_ff == flash_fe_pkg::OP_BUF_READ) ||
                       (cmd_ff == flash_fe_pkg::OP_MEM_READ) ||
                       (cmd_ff == flash_fe_pkg::OP_SEC_READ);
         end else begin
            load_now = tx_en_ff;
         end
      end
      fetch_byte = 8'h00;
      nxt_rd_ptr = fetch_ptr;
      nxt_rd_ptr.col = (fetch_ptr.col == col_last) ? 9'h000 : fetch_ptr.col + 9'h001;
      case (fetch_cmd)
         flash_fe_pkg::OP_STATUS: begin
            fetch_byte = {!busy, overrun_ff, 5'h00, page256_ff};
         end
         flash_fe_pkg::OP_ID: begin
            if (fetch_ptr.col == 9'h000) begin
               fetch_byte = MAKER_ID; // R15
            end else if (fetch_ptr.col == 9'h001) begin
               fetch_byte = DEVICE_ID;
            end
            nxt_rd_ptr.col = (fetch_ptr.col == 9'h002) ? fetch_ptr.col : fetch_ptr.col + 9'h001;
         end
         flash_fe_pkg::OP_BUF_READ: begin
            fetch_byte = page_buf[fetch_ptr.col];
         end
         flash_fe_pkg::OP_MEM_READ: begin
            fetch_byte = main_mem[flat(fetch_ptr.page, fetch_ptr.col)];
            if (fetch_ptr.col == col_last) begin
               nxt_rd_ptr.page = fetch_ptr.page + 9'h001; // Runs through whole array
            end
         end
         flash_fe_pkg::OP_SEC_READ: begin
            if (fetch_ptr.col <= flash_fe_pkg::SEC_USER_LAST) begin
               fetch_byte = sec_user[fetch_ptr.col[5:0]]; // R14
            end else begin
               fetch_byte = UID_SEED ^ {1'b0, fetch_ptr.col[6:0]};
            end
            nxt_rd_ptr.col = (fetch_ptr.col == flash_fe_pkg::SEC_LAST) ? 9'h000 :
                             fetch_ptr.col + 9'h001;
         end
         default: begin
            fetch_byte = 8'h00;
         end
      endcase
   end

   // Transmit side; a leading fall in clock-idle-high mode finds tx off
   always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         tx_byte_ff <= '0;
         tx_en_ff <= 1'b0;
         rd_ptr_ff <= '0;
         sdo_ff <= 1'b0;
      end else if (desel_lvl_ff) begin
         tx_en_ff <= 1'b0;
      end else begin
         if (load_now) begin
            tx_byte_ff <= fetch_byte;
            tx_en_ff <= 1'b1;
            rd_ptr_ff <= nxt_rd_ptr;
         end
         if (sck_fall && tx_en_ff) begin
            sdo_ff <= tx_byte_ff[3'd7 - bit_cnt_ff]; // R07 R08 R17
         end
      end
   end

   always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         sdo_oe_ff <= 1'b0;
         standby_ff <= 1'b1;
      end else begin
         sdo_oe_ff <= !desel_lvl_ff && tx_en_ff && !sel_rise; // R02
         standby_ff <= desel_lvl_ff && !busy; // R01 R05
      end
   end

   // Buffer write stream through the FIFO
   assign push_valid = last_bit && (bytes_ff == flash_fe_pkg::BYTES_CMD_ADDR) &&
                       (cmd_ff == flash_fe_pkg::OP_BUF_WRITE);
   assign push_word = '{col: wr_col_ff, data: rx_new};
   assign pop_ready = !busy;

   always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         wr_col_ff <= '0;
      end else if (last_bit && (bytes_ff == 3'(flash_fe_pkg::ADDR_BYTES))) begin
         wr_col_ff <= fetch_ptr.col;
      end else if (push_valid) begin
         wr_col_ff <= (wr_col_ff == col_last) ? 9'h000 : wr_col_ff + 9'h001;
      end
   end

   always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         overrun_ff <= 1'b0;
      end else if (push_valid && !push_ready) begin
         overrun_ff <= 1'b1;
      end else if (load_now && (fetch_cmd == flash_fe_pkg::OP_STATUS)) begin
         overrun_ff <= 1'b0;
      end
   end

   fe_fifo #(
      .WIDTH($bits(flash_fe_pkg::buf_word_t)),
      .DEPTH(flash_fe_pkg::FIFO_DEPTH)
   ) u_wr_fifo (
      .clk_in(CLOCK_IN),
      .nrst_in(NRST_IN),
      .wr_data_in(push_word),
      .wr_valid_in(push_valid),
      .wr_ready_out(push_ready),
      .rd_data_out(pop_word),
      .rd_valid_out(pop_valid),
      .rd_ready_in(pop_ready)
   );

   always_ff @(posedge CLOCK_IN) begin
      if (pop_valid && pop_ready) begin
         page_buf[pop_word.col] <= pop_word.data; // R11
      end
   end

   // Page size setting, applied on deselect
   always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         page256_ff <= flash_fe_pkg::RST_PAGE256;
      end else if (sel_rise && !busy && (bytes_ff >= flash_fe_pkg::BYTES_CMD_ONLY)) begin
         if (cmd_ff == flash_fe_pkg::OP_PAGE256) begin
            page256_ff <= 1'b1; // R10
         end else if (cmd_ff == flash_fe_pkg::OP_PAGE264) begin
            page256_ff <= 1'b0;
         end
      end
   end

   // Self-timed engine, launched only by the closing select edge
   assign launch_ptr = decode(addr_ff, page256_ff);
   assign eng_index = flat(eng_page_ff, eng_col_ff);

   always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         eng_state_ff <= flash_fe_pkg::ENG_IDLE;
         eng_page_ff <= '0;
         eng_last_ff <= '0;
         eng_col_ff <= '0;
      end else begin
         unique case (eng_state_ff)
            flash_fe_pkg::ENG_IDLE: begin
               eng_col_ff <= '0;
               if (sel_rise) begin // R04 R18
                  if (bytes_ff == flash_fe_pkg::BYTES_CMD_ADDR) begin
                     unique case (cmd_ff)
                        flash_fe_pkg::OP_PROGRAM: begin
                           eng_state_ff <= flash_fe_pkg::ENG_PROG;
                           eng_page_ff <= launch_ptr.page;
                           eng_last_ff <= launch_ptr.page;
                        end
                        flash_fe_pkg::OP_ERASE_PAGE: begin
                           eng_state_ff <= flash_fe_pkg::ENG_ERASE; // R13
                           eng_page_ff <= launch_ptr.page;
                           eng_last_ff <= launch_ptr.page;
                        end
                        flash_fe_pkg::OP_ERASE_BLOCK: begin
                           eng_state_ff <= flash_fe_pkg::ENG_ERASE; // R13
                           eng_page_ff <= {launch_ptr.page[8:3], 3'b000};
                           eng_last_ff <= {launch_ptr.page[8:3], 3'b000} +
                                          9'(flash_fe_pkg::BLOCK_PAGES - 1);
                        end
                        flash_fe_pkg::OP_ERASE_SECTOR: begin
                           eng_state_ff <= flash_fe_pkg::ENG_ERASE; // R13
                           eng_page_ff <= {launch_ptr.page[8:7], 7'h00};
                           eng_last_ff <= {launch_ptr.page[8:7], 7'h00} +
                                          9'(flash_fe_pkg::SECTOR_PAGES - 1);
                        end
                        default: begin
                           eng_state_ff <= flash_fe_pkg::ENG_IDLE;
                        end
                     endcase
                  end
                  if (bytes_ff >= flash_fe_pkg::BYTES_CMD_ONLY) begin
                     if (cmd_ff == flash_fe_pkg::OP_ERASE_CHIP) begin
                        eng_state_ff <= flash_fe_pkg::ENG_ERASE; // R13
                        eng_page_ff <= '0;
                        eng_last_ff <= 9'(flash_fe_pkg::NUM_PAGES - 1);
                     end else if (cmd_ff == flash_fe_pkg::OP_SEC_PROG) begin
                        eng_state_ff <= flash_fe_pkg::ENG_SECPROG;
                     end
                  end
               end
            end
            flash_fe_pkg::ENG_PROG: begin
               eng_col_ff <= eng_col_ff + 9'h001; // R12
               if (eng_col_ff == col_last) begin
                  eng_state_ff <= flash_fe_pkg::ENG_IDLE;
               end
            end
            flash_fe_pkg::ENG_ERASE: begin
               eng_col_ff <= (eng_col_ff == flash_fe_pkg::BIG_LAST) ? 9'h000 :
                             eng_col_ff + 9'h001; // R12
               if (eng_col_ff == flash_fe_pkg::BIG_LAST) begin
                  eng_page_ff <= eng_page_ff + 9'h001;
                  if (eng_page_ff == eng_last_ff) begin
                     eng_state_ff <= flash_fe_pkg::ENG_IDLE;
                  end
               end
            end
            flash_fe_pkg::ENG_SECPROG: begin
               eng_col_ff <= eng_col_ff + 9'h001; // R12
               if (eng_col_ff == flash_fe_pkg::SEC_USER_LAST) begin
                  eng_state_ff <= flash_fe_pkg::ENG_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge CLOCK_IN) begin
      if (eng_state_ff == flash_fe_pkg::ENG_PROG) begin
         main_mem[eng_index] <= page_buf[eng_col_ff];
      end else if (eng_state_ff == flash_fe_pkg::ENG_ERASE) begin
         main_mem[eng_index] <= 8'hff;
      end
   end

   always_ff @(posedge CLOCK_IN) begin
      if (eng_state_ff == flash_fe_pkg::ENG_SECPROG) begin
         sec_user[eng_col_ff[5:0]] <= sec_user[eng_col_ff[5:0]] & page_buf[eng_col_ff];
      end
   end

   assign SDO_OUT = sdo_ff;
   assign SDO_OE_OUT = sdo_oe_ff;
   assign STANDBY_OUT = standby_ff;

   sequence s_desel;
      desel_lvl_ff;
   endsequence
   sequence s_byte_start;
      sck_fall && tx_en_ff && !desel_lvl_ff && (bit_cnt_ff == 3'd0);
   endsequence

   property p_hiz;
      @(posedge CLOCK_IN) disable iff (!NRST_IN) s_desel |=> !SDO_OE_OUT;
   endproperty
   a_hiz: assert property (p_hiz) else $error("output driven while deselected"); // R02
   property p_ignore_in;
      @(posedge CLOCK_IN) disable iff (!NRST_IN)
         desel_lvl_ff && $past(desel_lvl_ff) |-> bit_cnt_ff == 3'd0 && bytes_ff == 3'd0;
   endproperty
   a_ignore_in: assert property (p_ignore_in) else $error("input taken while deselected"); // R03
   property p_launch_edge;
      @(posedge CLOCK_IN) disable iff (!NRST_IN)
         !busy ##1 busy |-> $past(sel_rise);
   endproperty
   a_launch_edge: assert property (p_launch_edge) else $error("engine started off edge"); // R04
   property p_standby_wait;
      @(posedge CLOCK_IN) disable iff (!NRST_IN) busy |=> !STANDBY_OUT;
   endproperty
   a_standby_wait: assert property (p_standby_wait) else $error("standby while busy"); // R05
   property p_rise_count;
      @(posedge CLOCK_IN) disable iff (!NRST_IN)
         sck_rise && !desel_lvl_ff && !sel_fall |=> bit_cnt_ff == $past(bit_cnt_ff) + 3'd1;
   endproperty
   a_rise_count: assert property (p_rise_count) else $error("bit not taken on rise"); // R06
   property p_out_on_fall;
      @(posedge CLOCK_IN) disable iff (!NRST_IN) !$past(sck_fall) |-> $stable(SDO_OUT);
   endproperty
   a_out_on_fall: assert property (p_out_on_fall) else $error("output moved off fall"); // R07
   property p_msb_first;
      @(posedge CLOCK_IN) disable iff (!NRST_IN)
         s_byte_start |=> SDO_OUT == $past(tx_byte_ff[7]);
   endproperty
   a_msb_first: assert property (p_msb_first) else $error("first bit not msb"); // R17
   property p_lead_fall;
      @(posedge CLOCK_IN) disable iff (!NRST_IN)
         sel_fall ##1 (!sck_rise && !load_now)[*2] |-> !tx_en_ff;
   endproperty
   a_lead_fall: assert property (p_lead_fall) else $error("output armed before bits"); // R08
   property p_self_timed;
      @(posedge CLOCK_IN) disable iff (!NRST_IN)
         busy ##1 busy |-> $changed(eng_col_ff);
   endproperty
   a_self_timed: assert property (p_self_timed) else $error("engine stalled"); // R12
endmodule

// ### verif/spi_host_model.sv
// Host side of the serial link: frames, clock, data in and out.
// Assumes a 40 MHz core clock; link phases are 4 core cycles.
`timescale 1ns/1ps
module spi_host_model (
   input wire logic clk_in, // Core clock
   input wire logic sdo_in, // Device data out
   output logic sel_n_out, // Select, low
   output logic sclk_out, // Link clock
   output logic sdi_out // Data to device
);
   initial begin
      sel_n_out = 1'b1;
      sclk_out = 1'b0;
      sdi_out = 1'b0;
   end
   task automatic half();
      repeat (4) @(posedge clk_in);
   endtask
   // Link activity with the device deselected
   task automatic noise();
      repeat (8) begin
         sclk_out <= ~sclk_out;
         sdi_out <= 1'($urandom);
         half();
      end
   endtask
   task automatic xfer(input logic [7:0] tx[$], input int nrd, input bit idle_hi,
                       output logic [7:0] rx[$]);
      logic [7:0] b;
      rx = {};
      sclk_out <= idle_hi;
      half();
      sel_n_out <= 1'b0;
      half();
      for (int i = 0; i < tx.size() + nrd; i++) begin
         b = (i < tx.size()) ? tx[i] : 8'($urandom);
         for (int k = 7; k >= 0; k--) begin
            sclk_out <= 1'b0;
            sdi_out <= b[k];
            half();
            sclk_out <= 1'b1;
            half();
            b[k] = sdo_in;
         end
         if (i >= tx.size()) rx.push_back(b);
      end
      sclk_out <= idle_hi;
      half();
      sel_n_out <= 1'b1;
      sdi_out <= ~sdi_out;
      half();
   endtask
endmodule

// ### verif/test_serial_flash_fe.sv
// Bench for the serial flash front end, driven through the host model.
// Assumes the package, design and host model are compiled first.
`timescale 1ns/1ps
module test_serial_flash_fe;
   localparam logic [7:0] MKR = 8'h5a; // Arbitrary value
   localparam logic [7:0] DEV = 8'ha5; // Arbitrary value
   localparam logic [7:0] UID = 8'h3c; // Arbitrary value
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic sel_n, sclk, sdi, sdo, sdo_oe, stby, sdo_seen;
   logic [7:0] tx[$], rx[$], dat[$];
   logic [7:0] col;
   int n_errors = 0;
   int tests_run = 0;
   int cyc = 0;
   initial forever #12.5 clk = ~clk;
   serial_flash_fe #(.MAKER_ID(MKR), .DEVICE_ID(DEV), .UID_SEED(UID)) u_dut (
      .CLOCK_IN(clk), .NRST_IN(nrst), .SEL_N_IN(sel_n), .SCLK_IN(sclk), .SDI_IN(sdi),
      .SDO_OUT(sdo), .SDO_OE_OUT(sdo_oe), .STANDBY_OUT(stby));
   // Undriven line seen as inverted last value
   assign sdo_seen = sdo_oe ? sdo : !sdo;
   spi_host_model u_host (.clk_in(clk), .sdo_in(sdo_seen), .sel_n_out(sel_n), .sclk_out(sclk),
      .sdi_out(sdi));
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d errors %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic wait_idle();
      for (int i = 0; i < 40000 && stby !== 1'b1; i++) @(posedge clk);
      check({7'h0, stby}, 8'h01);
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         n_errors++;
         end_sim();
      end
   end
   initial begin
      void'($urandom(4074));
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      repeat (6) @(posedge clk);
      check({6'h0, sdo_oe, stby}, 8'h01);
      u_host.noise();
      tx = {flash_fe_pkg::OP_STATUS};
      u_host.xfer(tx, 1, 1'b0, rx);
      check(rx[0], 8'h80);
      tx = {flash_fe_pkg::OP_ID};
      u_host.xfer(tx, 2, 1'b1, rx);
      check(rx[0], MKR);
      check(rx[1], DEV);
      tx = {flash_fe_pkg::OP_SEC_READ, 8'h00, 8'h00, 8'h40};
      u_host.xfer(tx, 1, 1'b0, rx);
      check(rx[0], UID ^ 8'h40);
      tx = {flash_fe_pkg::OP_ERASE_SECTOR, 8'h00, 8'h00, 8'h00};
      u_host.xfer(tx, 0, 1'b0, rx);
      repeat (4) @(posedge clk);
      check({7'h0, stby}, 8'h00);
      col = 8'($urandom_range(0, 255));
      tx = {flash_fe_pkg::OP_BUF_WRITE, 8'h00, 8'h00, col};
      repeat (10) begin
         dat.push_back(8'($urandom));
         tx.push_back(dat[$]);
      end
      u_host.xfer(tx, 0, 1'b0, rx);
      tx = {flash_fe_pkg::OP_STATUS};
      u_host.xfer(tx, 4, 1'b0, rx);
      check(rx[0], 8'h40);
      check(rx[3], 8'h00);
      wait_idle();
      tx = {flash_fe_pkg::OP_MEM_READ, 8'h00, 8'h0a, col};
      u_host.xfer(tx, 8, 1'b0, rx);
      foreach (rx[i]) check(rx[i], 8'hff);
      tx = {flash_fe_pkg::OP_BUF_READ, 8'h00, 8'h00, col};
      u_host.xfer(tx, 8, 1'b1, rx);
      foreach (rx[i]) check(rx[i], dat[i]);
      tx = {flash_fe_pkg::OP_PROGRAM, 8'h00, 8'h0a, 8'h00};
      u_host.xfer(tx, 0, 1'b0, rx);
      wait_idle();
      tx = {flash_fe_pkg::OP_MEM_READ, 8'h00, 8'h0a, col};
      u_host.xfer(tx, 8, 1'b0, rx);
      foreach (rx[i]) check(rx[i], dat[i]);
      tx = {flash_fe_pkg::OP_ERASE_PAGE, 8'h00, 8'h0a, 8'h00};
      u_host.xfer(tx, 0, 1'b0, rx);
      wait_idle();
      tx = {flash_fe_pkg::OP_MEM_READ, 8'h00, 8'h0a, col};
      u_host.xfer(tx, 8, 1'b0, rx);
      foreach (rx[i]) check(rx[i], 8'hff);
      tx = {flash_fe_pkg::OP_PAGE256};
      u_host.xfer(tx, 0, 1'b0, rx);
      tx = {flash_fe_pkg::OP_STATUS};
      u_host.xfer(tx, 1, 1'b0, rx);
      check(rx[0], 8'h81);
      tx = {flash_fe_pkg::OP_PAGE264};
      u_host.xfer(tx, 0, 1'b1, rx);
      tx = {flash_fe_pkg::OP_STATUS};
      u_host.xfer(tx, 1, 1'b1, rx);
      check(rx[0], 8'h80);
      end_sim();
   end
endmodule
